// ---- hw/dsb_pkg.sv ----
// constants and types shared by the deep sleep status block
package dsb_pkg;
   // register byte offsets on the bus
   localparam logic [3:0] OFF_RST_CTRL = 4'h0;
   localparam logic [3:0] OFF_SUPPLY = 4'h4;
   localparam logic [3:0] OFF_DS_CTRL = 4'h8;
   localparam logic [3:0] OFF_WAKE = 4'hc;
   // reset_control_status field positions
   localparam int RC_CORE_POR = 0;
   localparam int RC_FLASH_BIAS = 8;
   // supply_reset_status field positions
   localparam int SR_BACKUP_EXIT = 0;
   localparam int SR_BACKUP_POR = 1;
   localparam int SR_POWERUP = 2;
   localparam int SR_BROWNOUT = 3;
   // deep_sleep_control field positions
   localparam int DC_HOLD = 0;
   localparam int DC_BROWNOUT = 1;
   localparam int DC_SELECT = 15;
   // deep_sleep_wake_cause field positions
   localparam int WK_SUPPLY_POR = 0;
   localparam int WK_EXT_RESET = 2;
   localparam int WK_ALARM = 3;
   localparam int WK_WATCHDOG = 4;
   localparam int WK_FAULT = 7;
   // values after power-on and writable masks
   localparam logic [15:0] RST_CTRL_RESET = 16'h0001;
   localparam logic [15:0] RST_CTRL_MASK = 16'h0101;
   localparam logic [15:0] SUPPLY_RESET = 16'h000e;
   localparam logic [15:0] SUPPLY_MASK = 16'h000f;
   localparam logic [15:0] DS_CTRL_RESET = 16'h0000;
   localparam logic [15:0] DS_CTRL_MASK = 16'h8003;
   localparam logic [15:0] WAKE_RESET = 16'h0000;
   localparam logic [15:0] WAKE_MASK = 16'h009d;
   // bus phase states
   typedef enum logic [2:0] {
      DSB_IDLE = 3'b001,
      DSB_WRITE = 3'b010,
      DSB_READ = 3'b100
   } dsb_bus_t;
endpackage

// ---- hw/dsb_flag_bank.sv ----
// bank of hardware-set flags with software clear, set wins
`timescale 1ns/100ps
module dsb_flag_bank #(
   parameter int WIDTH = 16,
   parameter logic [15:0] INIT = 16'h0000
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // events and clears
   input wire logic [WIDTH-1:0] set_i,
   input wire logic [WIDTH-1:0] clr_i,
   // flag state
   output logic [WIDTH-1:0] flag_o
);
   initial begin
      if (WIDTH < 1 || WIDTH > 16) $error("flag bank width out of range");
   end
   logic [WIDTH-1:0] flag_q;
   logic [WIDTH-1:0] flag_d;
   always_comb begin
      flag_d = (flag_q & ~clr_i) | set_i;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_q <= INIT[WIDTH-1:0];
      end else begin
         flag_q <= flag_d;
      end
   end
   assign flag_o = flag_q;
endmodule

// ---- hw/dsb_double_write.sv ----
// unlock that lets a value through only on its second write
`timescale 1ns/100ps
module dsb_double_write #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // write strobe and data
   input wire logic wr_i,
   input wire logic [WIDTH-1:0] data_i,
   // commit pulse
   output logic commit_o
);
   initial begin
      if (WIDTH < 1) $error("double write width too small");
   end
   logic armed_q;
   logic [WIDTH-1:0] val_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         armed_q <= 1'b0;
         val_q <= '0;
      end else if (wr_i) begin
         armed_q <= ~(armed_q && val_q == data_i);
         val_q <= data_i;
      end
   end
   assign commit_o = wr_i && armed_q && val_q == data_i;
endmodule

// ---- hw/dsb_top.sv ----
// deep sleep, supply reset and wake cause status with an ahb-lite slave
`timescale 1ns/100ps
module dsb_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // supply and reset events, one-cycle pulses; backup_present_i and main_supply_ok_i are levels
   input wire logic supply_brownout_i,
   input wire logic supply_powerup_i,
   input wire logic core_por_i,
   input wire logic backup_present_i,
   input wire logic backup_low_i,
   input wire logic first_powerup_i,
   input wire logic main_supply_ok_i,
   // sleep events
   input wire logic sleep_instr_i,
   input wire logic ds_wake_i,
   input wire logic ds_brownout_enable_i,
   input wire logic ds_supply_low_i,
   input wire logic ds_fault_i,
   input wire logic ds_watchdog_i,
   input wire logic ds_alarm_i,
   input wire logic ext_reset_enable_i,
   input wire logic ext_reset_i,
   input wire logic supply_por_detect_i,
   // power and pin control outputs
   output logic deep_sleep_o,
   output logic sleep_o,
   output logic flash_bias_on_o,
   output logic pin_hold_o,
   output logic on_backup_o,
   output logic por_request_o
);
   typedef struct packed {
      dsb_pkg::dsb_bus_t ph;
      logic [3:0] addr;
      logic [31:0] rdata;
      logic [15:0] rst_ctrl;
      logic [15:0] ds_ctrl;
      logic in_deep;
      logic in_sleep;
      logic on_backup;
      logic por_req;
      logic bias;
   } dsb_state_t;

   dsb_state_t s_q;
   dsb_state_t s_d;
   logic [3:0] sup_flags;
   logic [3:0] sup_set;
   logic [3:0] sup_clr;
   logic [7:0] wake_flags;
   logic [7:0] wake_set;
   logic [7:0] wake_clr;
   logic wr_sup;
   logic wr_wake;
   logic wr_dsc;
   logic wr_rc;
   logic wake_commit;
   logic dsc_commit;
   logic [15:0] wd;
   logic take;

   function automatic logic [15:0] read_reg(input logic [3:0] a, input logic [15:0] rc,
         input logic [15:0] sr, input logic [15:0] dc, input logic [15:0] wk);
      case (a)
         dsb_pkg::OFF_RST_CTRL: read_reg = rc & dsb_pkg::RST_CTRL_MASK;
         dsb_pkg::OFF_SUPPLY: read_reg = sr & dsb_pkg::SUPPLY_MASK;
         dsb_pkg::OFF_DS_CTRL: read_reg = dc & dsb_pkg::DS_CTRL_MASK;
         dsb_pkg::OFF_WAKE: read_reg = wk & dsb_pkg::WAKE_MASK;
         default: read_reg = 16'h0000;
      endcase
   endfunction

   assign wd = hwdata_i[15:0];
   assign take = hsel_i && hready_i && htrans_i[1];
   assign wr_rc = s_q.ph == dsb_pkg::DSB_WRITE && s_q.addr == dsb_pkg::OFF_RST_CTRL;
   assign wr_sup = s_q.ph == dsb_pkg::DSB_WRITE && s_q.addr == dsb_pkg::OFF_SUPPLY;
   assign wr_dsc = s_q.ph == dsb_pkg::DSB_WRITE && s_q.addr == dsb_pkg::OFF_DS_CTRL;
   assign wr_wake = s_q.ph == dsb_pkg::DSB_WRITE && s_q.addr == dsb_pkg::OFF_WAKE;

   // supply flags: hardware sets, software zero bits clear
   always_comb begin
      sup_set = '0;
      sup_set[dsb_pkg::SR_BROWNOUT] = supply_brownout_i;
      sup_set[dsb_pkg::SR_POWERUP] = supply_powerup_i;
      sup_set[dsb_pkg::SR_BACKUP_POR] = (core_por_i && !backup_present_i)
         || (s_q.on_backup && backup_low_i) || first_powerup_i;
      sup_set[dsb_pkg::SR_BACKUP_EXIT] = core_por_i && s_q.on_backup
         && backup_present_i;
      sup_clr = wr_sup ? ~wd[3:0] : 4'h0;
   end

   dsb_flag_bank #(
      .WIDTH(4),
      .INIT(dsb_pkg::SUPPLY_RESET)
   ) u_supply (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(sup_set),
      .clr_i(sup_clr),
      .flag_o(sup_flags)
   );

   dsb_double_write #(
      .WIDTH(16)
   ) u_wake_unlock (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_wake),
      .data_i(wd),
      .commit_o(wake_commit)
   );

   dsb_double_write #(
      .WIDTH(16)
   ) u_sel_unlock (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_dsc),
      .data_i(wd),
      .commit_o(dsc_commit)
   );

   // wake cause flags
   always_comb begin
      wake_set = '0;
      wake_set[dsb_pkg::WK_FAULT] = s_q.in_deep && ds_fault_i;
      wake_set[dsb_pkg::WK_WATCHDOG] = s_q.in_deep && ds_watchdog_i;
      wake_set[dsb_pkg::WK_ALARM] = s_q.in_deep && ds_alarm_i;
      wake_set[dsb_pkg::WK_EXT_RESET] = s_q.in_deep && ext_reset_enable_i
         && ext_reset_i;
      wake_set[dsb_pkg::WK_SUPPLY_POR] = supply_por_detect_i;
      wake_set = wake_set | (wake_commit ? wd[7:0] & dsb_pkg::WAKE_MASK[7:0] : 8'h00);
      wake_clr = wake_commit ? ~wd[7:0] : 8'h00;
   end

   dsb_flag_bank #(
      .WIDTH(8),
      .INIT(dsb_pkg::WAKE_RESET)
   ) u_wake (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(wake_set),
      .clr_i(wake_clr),
      .flag_o(wake_flags)
   );

   always_comb begin
      s_d = s_q;
      s_d.por_req = 1'b0;
      // bus phases
      case (s_q.ph)
         dsb_pkg::DSB_IDLE,
         dsb_pkg::DSB_WRITE,
         dsb_pkg::DSB_READ: begin
            s_d.ph = dsb_pkg::DSB_IDLE;
            if (take) begin
               s_d.ph = hwrite_i ? dsb_pkg::DSB_WRITE : dsb_pkg::DSB_READ;
               s_d.addr = haddr_i[3:0];
               if (!hwrite_i) begin
                  s_d.rdata = {16'h0000, read_reg(haddr_i[3:0], s_q.rst_ctrl,
                     {12'h000, sup_flags}, s_q.ds_ctrl, {8'h00, wake_flags})};
               end
            end
         end
         default: s_d.ph = dsb_pkg::DSB_IDLE;
      endcase
      // unmapped upper addresses: read zero, write lands nowhere
      if (take && haddr_i[31:4] != 28'h0000_000) begin
         s_d.addr = 4'h1;
         s_d.rdata = 32'h0000_0000;
      end
      // reset control register
      if (wr_rc) begin
         s_d.rst_ctrl = (s_q.rst_ctrl & ~wd) | 16'h0000;
         s_d.rst_ctrl[dsb_pkg::RC_FLASH_BIAS] = wd[dsb_pkg::RC_FLASH_BIAS];
         s_d.rst_ctrl[dsb_pkg::RC_CORE_POR] = s_q.rst_ctrl[dsb_pkg::RC_CORE_POR]
            & wd[dsb_pkg::RC_CORE_POR];
      end
      if (core_por_i) begin
         s_d.rst_ctrl[dsb_pkg::RC_CORE_POR] = 1'b1;
      end
      // deep sleep control register
      if (wr_dsc) begin
         s_d.ds_ctrl[dsb_pkg::DC_HOLD] = wd[dsb_pkg::DC_HOLD];
         s_d.ds_ctrl[dsb_pkg::DC_BROWNOUT] = s_q.ds_ctrl[dsb_pkg::DC_BROWNOUT]
            & wd[dsb_pkg::DC_BROWNOUT];
      end
      if (dsc_commit) begin
         s_d.ds_ctrl[dsb_pkg::DC_SELECT] = wd[dsb_pkg::DC_SELECT];
      end
      if (s_q.in_deep && ds_brownout_enable_i && ds_supply_low_i) begin
         s_d.ds_ctrl[dsb_pkg::DC_BROWNOUT] = 1'b1;
      end
      // sleep entry and exit
      if (sleep_instr_i && !s_q.in_deep && !s_q.in_sleep) begin
         if (s_q.ds_ctrl[dsb_pkg::DC_SELECT]) begin
            s_d.in_deep = 1'b1;
            s_d.ds_ctrl[dsb_pkg::DC_HOLD] = 1'b1;
         end else begin
            s_d.in_sleep = 1'b1;
         end
      end
      if (ds_wake_i || ext_reset_i) begin
         s_d.in_sleep = 1'b0;
      end
      if (s_q.in_deep && (ds_wake_i || wake_set[7:2] != 6'h00)) begin
         s_d.in_deep = 1'b0;
         s_d.ds_ctrl[dsb_pkg::DC_SELECT] = 1'b0;
      end
      // main supply loss and return
      if (!main_supply_ok_i) begin
         s_d.on_backup = 1'b1;
         s_d.in_deep = 1'b0;
         s_d.in_sleep = 1'b0;
      end else if (s_q.on_backup) begin
         s_d.on_backup = 1'b0;
         s_d.por_req = 1'b1;
      end
      s_d.bias = s_d.rst_ctrl[dsb_pkg::RC_FLASH_BIAS] || !(s_d.in_sleep
         || s_d.in_deep);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q.ph <= dsb_pkg::DSB_IDLE;
         s_q.addr <= 4'h0;
         s_q.rdata <= 32'h0000_0000;
         s_q.rst_ctrl <= dsb_pkg::RST_CTRL_RESET;
         s_q.ds_ctrl <= dsb_pkg::DS_CTRL_RESET;
         s_q.in_deep <= 1'b0;
         s_q.in_sleep <= 1'b0;
         s_q.on_backup <= 1'b0;
         s_q.por_req <= 1'b0;
         s_q.bias <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata_o = s_q.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign deep_sleep_o = s_q.in_deep;
   assign sleep_o = s_q.in_sleep;
   assign flash_bias_on_o = s_q.bias;
   assign pin_hold_o = s_q.ds_ctrl[dsb_pkg::DC_HOLD];
   assign on_backup_o = s_q.on_backup;
   assign por_request_o = s_q.por_req;
endmodule

// ---- verif/dsb_properties.sv ----
// concurrent checks on the ports of the deep sleep status block
`timescale 1ns/100ps
module dsb_properties (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // events
   input wire logic main_supply_ok_i,
   input wire logic sleep_instr_i,
   input wire logic ds_wake_i,
   input wire logic ds_supply_low_i,
   input wire logic ds_fault_i,
   input wire logic ds_watchdog_i,
   input wire logic ds_alarm_i,
   input wire logic ext_reset_i,
   input wire logic supply_por_detect_i,
   // outputs
   input wire logic deep_sleep_o,
   input wire logic sleep_o,
   input wire logic flash_bias_on_o,
   input wire logic pin_hold_o,
   input wire logic on_backup_o,
   input wire logic por_request_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd_taken;
   logic quiet;
   assign rd_taken = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   assign quiet = !(ds_wake_i || ds_fault_i || ds_watchdog_i || ds_alarm_i || ext_reset_i
      || supply_por_detect_i) && main_supply_ok_i;
   a_resp_okay: assert property (hresp_o == 1'b0) else $error("error response");
   a_ready_high: assert property (hreadyout_o) else $error("wait state inserted");
   a_read_stands: assert property (!rd_taken |=> $stable(hrdata_o)) else $error("rdata moved");
   a_backup_switch: assert property (!main_supply_ok_i |-> ##[1:2] on_backup_o)
      else $error("no backup switch");
   a_return_por: assert property (on_backup_o && main_supply_ok_i |-> ##[0:2] por_request_o)
      else $error("no por request");
   a_por_pulse: assert property (por_request_o |=> !por_request_o) else $error("long por pulse");
   a_deep_cause: assert property ($rose(deep_sleep_o) |-> $past(sleep_instr_i)
      || $past(sleep_instr_i, 2)) else $error("deep sleep without instruction");
   a_hold_entry: assert property ($rose(deep_sleep_o) |-> ##[0:1] pin_hold_o)
      else $error("pins not held");
   a_brownout_nowake: assert property (deep_sleep_o && ds_supply_low_i && quiet
      |=> deep_sleep_o) else $error("brownout woke device");
   a_bias_awake: assert property (!sleep_o && !deep_sleep_o |-> flash_bias_on_o)
      else $error("bias off while awake");
   c_deep: cover property ($rose(deep_sleep_o));
   c_por: cover property (por_request_o);
   c_brown: cover property (deep_sleep_o && ds_supply_low_i);
endmodule

bind dsb_top dsb_properties i_props (.clk_i, .rst_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
   .hrdata_o, .hreadyout_o, .hresp_o, .main_supply_ok_i, .sleep_instr_i, .ds_wake_i,
   .ds_supply_low_i, .ds_fault_i, .ds_watchdog_i, .ds_alarm_i, .ext_reset_i,
   .supply_por_detect_i, .deep_sleep_o, .sleep_o, .flash_bias_on_o, .pin_hold_o,
   .on_backup_o, .por_request_o);

// ---- verif/testbench.sv ----
// register and event tests of the deep sleep status block
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
   $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
`define PULSE(s) begin s <= 1'b1; @(posedge clk_i); s <= 1'b0; end
`define WAIT(c) for (int k = 0; k < 20 && !(c); k++) @(posedge clk_i);
module testbench;
   logic clk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o;
   logic [1:0] htrans_i = 0;
   logic [2:0] hsize_i = 3'b010;
   logic hready_i, hreadyout_o, hresp_o;
   logic supply_brownout_i = 0, supply_powerup_i = 0, core_por_i = 0, backup_present_i = 1;
   logic backup_low_i = 0, first_powerup_i = 0, main_supply_ok_i = 1, sleep_instr_i = 0;
   logic ds_wake_i = 0, ds_brownout_enable_i = 0, ds_supply_low_i = 0, ds_fault_i = 0;
   logic ds_watchdog_i = 0, ds_alarm_i = 0, ext_reset_enable_i = 0, ext_reset_i = 0;
   logic supply_por_detect_i = 0;
   logic deep_sleep_o, sleep_o, flash_bias_on_o, pin_hold_o, on_backup_o, por_request_o;
   int errors = 0, num_checks = 0, cyc = 0;
   assign hready_i = hreadyout_o;
   always #4 clk_i = ~clk_i;
   dsb_top i_dut (.clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
      .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .supply_brownout_i, .supply_powerup_i,
      .core_por_i, .backup_present_i, .backup_low_i, .first_powerup_i, .main_supply_ok_i,
      .sleep_instr_i, .ds_wake_i, .ds_brownout_enable_i, .ds_supply_low_i, .ds_fault_i,
      .ds_watchdog_i, .ds_alarm_i, .ext_reset_enable_i, .ext_reset_i, .supply_por_detect_i,
      .deep_sleep_o, .sleep_o, .flash_bias_on_o, .pin_hold_o, .on_backup_o, .por_request_o);
   task report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one ahb-lite single transfer; read data taken at the data phase edge
   task xfer(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [31:0] q);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= {28'h000_0000, a};
      htrans_i <= 2'b10;
      hwrite_i <= wr;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'b00;
      hwdata_i <= {16'h0000, d};
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      q = hrdata_o;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 16'h0000, q);
      `CHK(q, e)
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      // power-on values, and a reserved offset reads zero
      rd(dsb_pkg::OFF_RST_CTRL, 32'h0000_0001);
      rd(dsb_pkg::OFF_SUPPLY, 32'h0000_000e);
      rd(dsb_pkg::OFF_DS_CTRL, 32'h0000_0000);
      rd(dsb_pkg::OFF_WAKE, 32'h0000_0000);
      rd(4'h2, 32'h0000_0000);
      $display("test reset values done");
      // supply flags clear by software, set by hardware only
      wr(dsb_pkg::OFF_SUPPLY, 16'h0000);
      rd(dsb_pkg::OFF_SUPPLY, 32'h0000_0000);
      wr(dsb_pkg::OFF_SUPPLY, 16'h001f);
      rd(dsb_pkg::OFF_SUPPLY, 32'h0000_0000);
      `PULSE(supply_brownout_i)
      rd(dsb_pkg::OFF_SUPPLY, 32'h0000_0008);
      `PULSE(supply_powerup_i)
      `PULSE(first_powerup_i)
      rd(dsb_pkg::OFF_SUPPLY, 32'h0000_000e);
      $display("test supply flags done");
      // flash bias bit and core power-on flag
      wr(dsb_pkg::OFF_RST_CTRL, 16'h0100);
      rd(dsb_pkg::OFF_RST_CTRL, 32'h0000_0100);
      `PULSE(core_por_i)
      rd(dsb_pkg::OFF_RST_CTRL, 32'h0000_0101);
      $display("test reset control done");
      // deep sleep select needs two writes; hold, brownout and wake
      wr(dsb_pkg::OFF_DS_CTRL, 16'h0000);
      wr(dsb_pkg::OFF_DS_CTRL, 16'h8000);
      rd(dsb_pkg::OFF_DS_CTRL, 32'h0000_0000);
      wr(dsb_pkg::OFF_DS_CTRL, 16'h8000);
      wr(dsb_pkg::OFF_DS_CTRL, 16'h8000);
      rd(dsb_pkg::OFF_DS_CTRL, 32'h0000_8000);
      `PULSE(sleep_instr_i)
      `WAIT(deep_sleep_o === 1'b1)
      `CHK(deep_sleep_o, 1'b1)
      `CHK(pin_hold_o, 1'b1)
      ds_brownout_enable_i <= 1'b1;
      `PULSE(ds_supply_low_i)
      repeat (3) @(posedge clk_i);
      `CHK(deep_sleep_o, 1'b1)
      `PULSE(ds_watchdog_i)
      `WAIT(deep_sleep_o === 1'b0)
      `CHK(deep_sleep_o, 1'b0)
      rd(dsb_pkg::OFF_DS_CTRL, 32'h0000_0003);
      rd(dsb_pkg::OFF_WAKE, 32'h0000_0010);
      wr(dsb_pkg::OFF_DS_CTRL, 16'h0000);
      @(posedge clk_i);
      `CHK(pin_hold_o, 1'b0)
      $display("test deep sleep done");
      // wake cause writes act on the second write
      wr(dsb_pkg::OFF_WAKE, 16'h0000);
      rd(dsb_pkg::OFF_WAKE, 32'h0000_0010);
      wr(dsb_pkg::OFF_WAKE, 16'h0000);
      rd(dsb_pkg::OFF_WAKE, 32'h0000_0000);
      `PULSE(supply_por_detect_i)
      rd(dsb_pkg::OFF_WAKE, 32'h0000_0001);
      $display("test wake cause done");
      // ordinary sleep powers bias down when the bias bit is clear
      wr(dsb_pkg::OFF_RST_CTRL, 16'h0000);
      `PULSE(sleep_instr_i)
      @(posedge clk_i);
      `CHK(sleep_o, 1'b1)
      `CHK(flash_bias_on_o, 1'b0)
      `PULSE(ds_wake_i)
      @(posedge clk_i);
      `CHK(sleep_o, 1'b0)
      `CHK(flash_bias_on_o, 1'b1)
      // fault, alarm and enabled reset pin during deep sleep
      wr(dsb_pkg::OFF_DS_CTRL, 16'h8000);
      wr(dsb_pkg::OFF_DS_CTRL, 16'h8000);
      `PULSE(sleep_instr_i)
      `WAIT(deep_sleep_o === 1'b1)
      `CHK(deep_sleep_o, 1'b1)
      ext_reset_enable_i <= 1'b1;
      ds_fault_i <= 1'b1;
      ds_alarm_i <= 1'b1;
      ext_reset_i <= 1'b1;
      @(posedge clk_i);
      ds_fault_i <= 1'b0;
      ds_alarm_i <= 1'b0;
      ext_reset_i <= 1'b0;
      `WAIT(deep_sleep_o === 1'b0)
      `CHK(deep_sleep_o, 1'b0)
      rd(dsb_pkg::OFF_WAKE, 32'h0000_008d);
      $display("test deep sleep causes done");
      // supply loss and return
      main_supply_ok_i <= 1'b0;
      `WAIT(on_backup_o === 1'b1)
      `CHK(on_backup_o, 1'b1)
      `PULSE(core_por_i)
      rd(dsb_pkg::OFF_SUPPLY, 32'h0000_000f);
      wr(dsb_pkg::OFF_SUPPLY, 16'h000d);
      rd(dsb_pkg::OFF_SUPPLY, 32'h0000_000d);
      backup_present_i <= 1'b0;
      `PULSE(core_por_i)
      backup_present_i <= 1'b1;
      rd(dsb_pkg::OFF_SUPPLY, 32'h0000_000f);
      main_supply_ok_i <= 1'b1;
      `WAIT(por_request_o === 1'b1)
      `CHK(por_request_o, 1'b1)
      $display("test supply loss done");
      report_and_stop();
   end
endmodule
